// ---- rtl/psram_host.sv ----
// host controller for an octal ddr self-refresh psram
// assumes the caller knows the read latency programmed in config_reg_zero[7:4]
`timescale 1ns/1ps
module psram_host (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire logic        reqRead,
  input  wire logic        reqReg,
  input  wire logic        reqLinear,
  input  wire logic [31:0] reqAddr,
  input  wire logic [7:0]  reqLen,
  input  wire logic [3:0]  latCount,
  input  wire logic        wrValid,
  output logic             wrReady,
  input  wire logic [15:0] wrData,
  input  wire logic [1:0]  wrMask,
  output logic             rdValid,
  output logic [15:0]      rdData,
  output logic             busy,
  output logic             linkClk,
  output logic             clock_complement,
  output logic             selN,
  input  wire logic [7:0]  dqIn,
  output logic [7:0]       dqOut,
  output logic             dqOe,
  input  wire logic        rwdsIn,
  output logic             rw_data_strobe,
  output logic             rwdsOe
);
  psram_host_pkg::state_e st_r;
  logic [47:0] command_address_word;
  logic [7:0]  len_r;
  logic [7:0]  words_r;
  logic [3:0]  lat_r;
  logic        dbl_r;
  logic        zero_r;
  logic        rd_r;
  logic        ph_r;
  logic        half_r;
  logic [9:0]  cnt_r;
  logic [15:0] word_r;
  logic [1:0]  mask_r;
  logic        rwdsPrev_r;
  logic        rdHalf_r;
  logic [7:0]  rdA_r;
  logic        rdValid_r;
  logic [15:0] rdData_r;
  logic [7:0]  dqOut_r;
  logic        dqOe_r;
  logic        rwdsOut_r;
  logic        rwdsOe_r;
  logic        selN_r;
  pin_sync_if  sync ();

  pin_sync u_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .dqIn    (dqIn),
    .rwdsIn  (rwdsIn),
    .sync    (sync.src)
  );

  function automatic logic [7:0] caByte(input logic [47:0] ca, input logic [9:0] idx);
    case (idx)
      10'h000: caByte = ca[47:40];
      10'h001: caByte = ca[39:32];
      10'h002: caByte = ca[31:24];
      10'h003: caByte = ca[23:16];
      10'h004: caByte = ca[15:8];
      default: caByte = ca[7:0];
    endcase
  endfunction

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic        active;
  logic        halfEnd;
  logic [9:0]  latHalves;
  logic [9:0]  dataHalves;
  logic        preData;
  logic        loadA;
  logic        loadB;
  logic        stall;
  logic        rwdsEdge;
  logic [47:0] caNew;
  logic        regWrite;

  assign active     = (st_r != psram_host_pkg::ST_IDLE);
  assign latHalves  = {5'h00, lat_r, 1'b0} << dbl_r;
  assign dataHalves = {1'b0, len_r, 1'b0};
  assign preData    = (st_r == psram_host_pkg::ST_CMD && cnt_r == psram_host_pkg::CA_LAST_BYTE && zero_r)
                   || (st_r == psram_host_pkg::ST_LAT && cnt_r == latHalves - 10'h001 && !rd_r);
  assign loadA      = preData || (st_r == psram_host_pkg::ST_WDATA && cnt_r[0] && cnt_r + 10'h001 < dataHalves);
  assign loadB      = st_r == psram_host_pkg::ST_WDATA && !cnt_r[0] && cnt_r + 10'h001 < dataHalves;
  assign stall      = !ph_r && loadA && !wrValid;
  assign halfEnd    = active && ph_r;
  assign rwdsEdge   = sync.rwdsSync != rwdsPrev_r;
  assign regWrite   = reqReg && !reqRead;
  // command fields, register writes forced linear
  assign caNew      = {reqRead, reqReg, reqLinear | regWrite, reqAddr[31:3], psram_host_pkg::CA_RSVD, reqAddr[2:0]};

  assign reqReady         = !active;
  assign wrReady          = active && !ph_r && loadA && wrValid;
  assign busy             = active;
  assign linkClk          = half_r;
  assign clock_complement = !half_r;
  assign selN             = selN_r;
  assign dqOut            = dqOut_r;
  assign dqOe             = dqOe_r;
  assign rw_data_strobe   = rwdsOut_r;
  assign rwdsOe           = rwdsOe_r;
  assign rdValid          = rdValid_r;
  assign rdData           = rdData_r;

  // ---------------------------------------------------------------
  // sequencer: a link half-period is two host cycles, held longer while write data stalls
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r <= psram_host_pkg::ST_IDLE;
      ph_r <= 1'b0;
      half_r <= 1'b0;
      cnt_r <= 10'h000;
      selN_r <= 1'b1;
      command_address_word <= 48'h0000_0000_0000;
      len_r <= 8'h00;
      lat_r <= psram_host_pkg::LAT_RESET;
      rd_r <= 1'b0;
      zero_r <= 1'b0;
      dbl_r <= 1'b0;
    end else begin
      ph_r <= active && (stall ? ph_r : !ph_r);
      case (st_r)
        psram_host_pkg::ST_IDLE: begin
          // select falls with the clock held low; burst bounded by reqLen
          if (reqValid) begin
            command_address_word <= caNew;
            len_r <= reqLen;
            lat_r <= latCount;
            rd_r <= reqRead;
            zero_r <= regWrite;
            dbl_r <= 1'b0;
            cnt_r <= 10'h000;
            selN_r <= 1'b0;
            st_r <= psram_host_pkg::ST_SELECT;
          end
        end
        psram_host_pkg::ST_SELECT: begin
          if (halfEnd) begin
            half_r <= 1'b1;
            st_r <= psram_host_pkg::ST_CMD;
          end
        end
        psram_host_pkg::ST_CMD: begin
          // strobe high during command doubles latency
          if (sync.rwdsSync && cnt_r >= 10'h002) begin
            dbl_r <= 1'b1;
          end
          // six command bytes over three clocks
          if (halfEnd) begin
            half_r <= !half_r;
            cnt_r <= (cnt_r == psram_host_pkg::CA_LAST_BYTE) ? 10'h000 : cnt_r + 10'h001;
            if (cnt_r == psram_host_pkg::CA_LAST_BYTE) begin
              st_r <= zero_r ? psram_host_pkg::ST_WDATA : psram_host_pkg::ST_LAT;
            end
          end
        end
        psram_host_pkg::ST_LAT: begin
          // clock the initial latency, doubled when flagged
          if (halfEnd) begin
            half_r <= !half_r;
            cnt_r <= (cnt_r == latHalves - 10'h001) ? 10'h000 : cnt_r + 10'h001;
            if (cnt_r == latHalves - 10'h001) begin
              st_r <= rd_r ? psram_host_pkg::ST_RDATA : psram_host_pkg::ST_WDATA;
            end
          end
        end
        psram_host_pkg::ST_WDATA: begin
          if (halfEnd) begin
            half_r <= !half_r;
            cnt_r <= cnt_r + 10'h001;
            // stop on byte B's falling edge: one more edge would clock junk in
            if (cnt_r + 10'h002 == dataHalves) begin
              st_r <= psram_host_pkg::ST_DESEL;
            end
          end
        end
        psram_host_pkg::ST_RDATA: begin
          // keep clocking until every word has arrived
          if (halfEnd) begin
            half_r <= !half_r;
          end
          if (rdValid_r && words_r == len_r) begin
            st_r <= psram_host_pkg::ST_DESEL;
          end
        end
        psram_host_pkg::ST_DESEL: begin
          // park clock low, then raise select
          if (halfEnd) begin
            half_r <= 1'b0;
            if (!half_r) begin
              selN_r <= 1'b1;
              st_r <= psram_host_pkg::ST_IDLE;
            end
          end
        end
        default: st_r <= psram_host_pkg::ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin drive: bytes change mid half, centred on the next edge
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dqOut_r <= 8'h00;
      dqOe_r <= 1'b0;
      rwdsOut_r <= 1'b0;
      rwdsOe_r <= 1'b0;
      word_r <= 16'h0000;
      mask_r <= 2'h0;
    end else if (!active || st_r == psram_host_pkg::ST_DESEL) begin
      dqOe_r <= 1'b0;
      rwdsOe_r <= 1'b0;
    end else if (!ph_r && !stall) begin
      if (st_r == psram_host_pkg::ST_SELECT) begin
        dqOut_r <= caByte(command_address_word, 10'h000);
        dqOe_r <= 1'b1;
      end else if (st_r == psram_host_pkg::ST_CMD && cnt_r < psram_host_pkg::CA_LAST_BYTE) begin
        dqOut_r <= caByte(command_address_word, cnt_r + 10'h001);
      end else if (loadA) begin
        // byte A for the rising edge
        word_r <= wrData;
        mask_r <= wrMask;
        dqOut_r <= wrData[15:8];
        dqOe_r <= 1'b1;
        // strobe high masks; never on zero-latency
        rwdsOut_r <= !zero_r && wrMask[1];
      end else if (loadB) begin
        dqOut_r <= word_r[7:0];
        rwdsOut_r <= !zero_r && mask_r[0];
      end else if (st_r == psram_host_pkg::ST_CMD || st_r == psram_host_pkg::ST_RDATA) begin
        dqOe_r <= st_r == psram_host_pkg::ST_CMD;
      end
      // low preamble after turnaround; zero-latency never drives
      if (st_r == psram_host_pkg::ST_LAT && !rd_r && cnt_r >= psram_host_pkg::PREAMBLE_HALF) begin
        rwdsOe_r <= 1'b1;
        rwdsOut_r <= preData && wrMask[1];
      end
      if (st_r == psram_host_pkg::ST_LAT && cnt_r < psram_host_pkg::PREAMBLE_HALF) begin
        dqOe_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // read capture on strobe transitions
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rwdsPrev_r <= 1'b0;
      rdHalf_r <= 1'b0;
      rdA_r <= 8'h00;
      rdValid_r <= 1'b0;
      rdData_r <= 16'h0000;
      words_r <= 8'h00;
    end else begin
      rwdsPrev_r <= sync.rwdsSync;
      rdValid_r <= 1'b0;
      if (st_r != psram_host_pkg::ST_RDATA) begin
        rdHalf_r <= 1'b0;
        words_r <= 8'h00;
      end else if (rwdsEdge && !(rdValid_r && words_r == len_r)) begin
        // one byte per strobe transition, A first
        rdHalf_r <= !rdHalf_r;
        rdA_r <= sync.dqSync;
        if (rdHalf_r) begin
          rdData_r <= {rdA_r, sync.dqSync};
          rdValid_r <= 1'b1;
          words_r <= words_r + 8'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence selOpen;
    !linkClk ##1 !linkClk;
  endsequence
  sequence cmdDone;
    st_r == psram_host_pkg::ST_CMD && halfEnd && cnt_r == psram_host_pkg::CA_LAST_BYTE;
  endsequence

  a_sel_clk_idle:  assert property ($fell(selN) |-> selOpen) else $error("select fell with clock high");
  a_cmd_length:    assert property (cmdDone |=> st_r != psram_host_pkg::ST_CMD && linkClk) else $error("command phase length wrong");
  a_ca_read_bit:   assert property (st_r == psram_host_pkg::ST_CMD && cnt_r == 10'h000 && !ph_r
    |-> dqOut[7] == rd_r) else $error("read bit wrong");
  a_reg_wr_linear: assert property (zero_r && active |-> command_address_word[psram_host_pkg::CA_TYPE_BIT]) else $error("register write not linear");
  a_lat_count:     assert property (st_r == psram_host_pkg::ST_LAT && halfEnd && cnt_r == latHalves - 10'h001 |=> st_r == psram_host_pkg::ST_RDATA || st_r == psram_host_pkg::ST_WDATA) else $error("latency count wrong");
  a_preamble_low:  assert property (st_r == psram_host_pkg::ST_LAT && !rd_r && !ph_r &&
    cnt_r == latHalves - 10'h001 && cnt_r > psram_host_pkg::PREAMBLE_HALF |-> rwdsOe && !rw_data_strobe)
    else $error("no mask preamble");
  a_zero_no_rw_data_strobe:  assert property (zero_r && active |-> !rwdsOe) else $error("strobe driven on zero-latency write");
  a_mask_owned:    assert property (st_r == psram_host_pkg::ST_WDATA && !zero_r |-> rwdsOe) else $error("mask not driven");
  a_desel_hiz:     assert property (selN |-> !dqOe && !rwdsOe && !linkClk) else $error("pins driven while deselected");
  a_end_clk_idle:  assert property ($rose(selN) |-> !$past(linkClk) ##1 !linkClk [*2])
    else $error("select rose with clock high");
endmodule

// ---- rtl/psram_host_pkg.sv ----
// constants and types of the octal ddr psram host controller
// assumes one host clock; the link clock is made from it by a divide by four, stretched while write data stalls
package psram_host_pkg;

  // ---------------------------------------------------------------
  // command-address word layout
  // ---------------------------------------------------------------
  localparam int          CA_W         = 48;
  localparam int          CA_RD_BIT    = 47;
  localparam int          CA_SPACE_BIT = 46;
  localparam int          CA_TYPE_BIT  = 45;
  localparam int          CA_UPPER_LO  = 16;
  localparam logic [9:0]  CA_LAST_BYTE = 10'h005;
  localparam logic [12:0] CA_RSVD      = 13'h0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          SYS_PERIOD_NS  = 40;
  localparam int          LINK_PERIOD_NS = 4 * SYS_PERIOD_NS;
  localparam logic [9:0]  PREAMBLE_HALF  = 10'h001;
  localparam logic [3:0]  LAT_RESET      = 4'h6;

  // ---------------------------------------------------------------
  // controller states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SELECT = 3'h1,
    ST_CMD    = 3'h2,
    ST_LAT    = 3'h3,
    ST_WDATA  = 3'h4,
    ST_RDATA  = 3'h5,
    ST_DESEL  = 3'h6
  } state_e;

endpackage

// ---- rtl/pin_sync_if.sv ----
// synchronised copies of the data lanes and strobe
// assumes both modports sit in the host clock domain
`timescale 1ns/1ps
interface pin_sync_if;
  logic [7:0] dqSync;
  logic       rwdsSync;
  modport src (output dqSync, output rwdsSync);
  modport dst (input dqSync, input rwdsSync);
endinterface

// ---- rtl/pin_sync.sv ----
// two flip-flop synchronisers for the pins the device drives
// assumes raw pin levels arrive unrelated to sys_clk
`timescale 1ns/1ps
module pin_sync (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] dqIn,
  input  wire logic       rwdsIn,
  pin_sync_if.src         sync
);
  logic [8:0] raw;
  logic [8:0] meta_r;
  logic [8:0] sync_r;

  assign raw = {rwdsIn, dqIn};

  // ---------------------------------------------------------------
  // one synchroniser per pin
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 9; i++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      if (!nrst) begin
        meta_r[i] <= 1'b0;
        sync_r[i] <= 1'b0;
      end else begin
        meta_r[i] <= raw[i];
        sync_r[i] <= meta_r[i];
      end
    end
  end

  assign sync.dqSync   = sync_r[7:0];
  assign sync.rwdsSync = sync_r[8];
endmodule

// ---- test/psram_dev_model.sv ----
// device-side model of the octal ddr psram, 64-word array, 8-word wrap
// assumes the bench resolves the shared lanes and feeds both sides
`timescale 1ns/1ps
module psram_dev_model #(
  parameter logic [15:0] CFG0_INIT = 16'h0060
) (
  input  wire logic        sysClk,
  input  wire logic        linkClk,
  input  wire logic        selN,
  input  wire logic [7:0]  dqLine,
  input  wire logic        rwdsLine,
  input  wire logic        dqHostOe,
  input  wire logic        rwdsHostOe,
  input  wire logic        dblLat,
  output logic [7:0]       dqDev,
  output logic             dqDevOe,
  output logic             rwdsDev,
  output logic             rwdsDevOe,
  output logic [47:0]      lastCa,
  output logic             ruleBreak
);
  logic [15:0] mem [64];
  logic [15:0] cfg [2] = '{CFG0_INIT, 16'h0000};
  logic [15:0] word;
  logic [7:0]  byteA;
  logic [5:0]  addr;
  logic        maskA;
  logic        zeroLat = 1'b0;
  int          edges = 0;
  int          latEdges = 0;
  int          k;

  initial begin
    for (int i = 0; i < 64; i++) mem[i] = {8'h40 + 8'(i), 8'hBF - 8'(i)};
    {dqDev, dqDevOe, rwdsDev, rwdsDevOe, lastCa, ruleBreak} = '0;
  end

  // released lines show a changing pattern, never the last value
  // moved on the falling edge so it never races the link edges
  always @(negedge sysClk) begin
    if (!dqDevOe)
      dqDev <= ~dqDev;
    if (!rwdsDevOe)
      rwdsDev <= ~rwdsDev;
    if ((dqHostOe && dqDevOe) || (rwdsHostOe && rwdsDevOe) || (zeroLat && rwdsHostOe))
      ruleBreak <= 1'b1;
  end

  always @(negedge selN) begin
    if (linkClk === 1'b1)
      ruleBreak = 1'b1;
    edges = 0;
    rwdsDev = dblLat;
    rwdsDevOe = 1'b1;
  end

  always @(posedge selN) begin
    if (linkClk === 1'b1)
      ruleBreak = 1'b1;
    dqDevOe = 1'b0;
    rwdsDevOe = 1'b0;
    zeroLat = 1'b0;
  end

  always @(linkClk) begin
    if (selN === 1'b0) begin
      edges = edges + 1;
      if (edges <= 6)
        lastCa = {lastCa[39:0], dqLine};
      if (edges == 6) begin
        addr = {lastCa[18:16], lastCa[2:0]};
        zeroLat = !lastCa[47] && lastCa[46];
        // latency from config, doubled on refresh
        latEdges = zeroLat ? 0 : (rwdsDev ? 4 : 2) * int'(cfg[0][7:4]);
        rwdsDev = 1'b0;
        rwdsDevOe = lastCa[47];
      end else if (edges > 6 + latEdges) begin
        k = edges - 7 - latEdges;
        word = lastCa[46] ? cfg[lastCa[0]] : mem[addr];
        if (lastCa[47]) begin
          dqDev = k[0] ? word[7:0] : word[15:8];
          dqDevOe = 1'b1;
          rwdsDev = ~rwdsDev;
        end else if (!k[0]) begin
          // byte A on rise, high strobe masks
          byteA = dqLine;
          maskA = rwdsLine !== 1'b0;
        end else if (zeroLat) begin
          cfg[lastCa[0]] = {byteA, dqLine};
        end else begin
          if (!maskA)
            mem[addr][15:8] = byteA;
          if (rwdsLine === 1'b0)
            mem[addr][7:0] = dqLine;
        end
        // legacy wrap within 8 words or run linearly over the end
        if (k[0])
          addr = lastCa[45] ? addr + 6'h01 : {addr[5:3], addr[2:0] + 3'h1};
      end
    end
  end
endmodule

// ---- test/test_psram_host.sv ----
// self-checking bench for the octal ddr psram host controller
// assumes psram_dev_model on the link; the host makes the link clock
`timescale 1ns/1ps
module test_psram_host;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        reqValid = 1'b0, reqRead = 1'b0, reqReg = 1'b0, reqLinear = 1'b0;
  logic [31:0] reqAddr = 32'h0;
  logic [7:0]  reqLen = 8'h01;
  logic [3:0]  latCount = 4'h6;
  logic        wrValid = 1'b0, wrTaken = 1'b0, dblLat = 1'b0;
  logic [15:0] wrData = 16'h0;
  logic [1:0]  wrMask = 2'h0;
  logic        reqReady, wrReady, rdValid, busy, linkClk, clkComp, selN, dqOe, rwdsOut, rwdsOe;
  logic        dqDevOe, rwdsDev, rwdsDevOe, ruleBreak;
  logic [15:0] rdData;
  logic [7:0]  dqOut, dqDev;
  logic [47:0] lastCa;
  wire  [7:0]  dqIn = dqOe ? dqOut : dqDev;
  wire         rwdsIn = rwdsOe ? rwdsOut : rwdsDev;
  logic [15:0] shadow [64];
  logic [15:0] cfgShadow [2] = '{16'h0060, 16'h0000};
  logic [15:0] rdQ [$];
  logic [17:0] wrQ [$];
  int          fail_count = 0;
  int          samples_checked = 0;

  always #20 sys_clk = ~sys_clk;

  psram_host uut (.sys_clk(sys_clk), .nrst(nrst), .reqValid(reqValid), .reqReady(reqReady),
    .reqRead(reqRead), .reqReg(reqReg), .reqLinear(reqLinear), .reqAddr(reqAddr), .reqLen(reqLen),
    .latCount(latCount), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData), .wrMask(wrMask),
    .rdValid(rdValid), .rdData(rdData), .busy(busy), .linkClk(linkClk), .clock_complement(clkComp),
    .selN(selN), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .rwdsIn(rwdsIn),
    .rw_data_strobe(rwdsOut), .rwdsOe(rwdsOe));

  psram_dev_model #(.CFG0_INIT(16'h0060)) dev (.sysClk(sys_clk), .linkClk(linkClk), .selN(selN),
    .dqLine(dqIn), .rwdsLine(rwdsIn), .dqHostOe(dqOe), .rwdsHostOe(rwdsOe), .dblLat(dblLat),
    .dqDev(dqDev), .dqDevOe(dqDevOe), .rwdsDev(rwdsDev), .rwdsDevOe(rwdsDevOe), .lastCa(lastCa),
    .ruleBreak(ruleBreak));

  task automatic check(input logic [47:0] expV, input logic [47:0] gotV);
    samples_checked++;
    if (gotV !== expV) begin
      fail_count++;
      $display("mismatch at %0t ns: expected %h got %h", $time, expV, gotV);
    end
  endtask

  task automatic give_verdict();
    $display("checked %0d values, %0d mismatches", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // one transfer: note expectations, request, wait, compare
  // ---------------------------------------------------------------
  task automatic xfer(input logic rd, input logic rg, input logic lin, input logic [5:0] a, input int n,
                      input logic [15:0] rv);
    logic [5:0]  p;
    logic [15:0] d;
    logic [1:0]  m;
    logic [31:0] ra;
    int          t;
    p = a;
    ra = rg ? (32'h0000_0800 | {31'h0, a[0]}) : {26'h0, a};
    for (int i = 0; i < n; i++) begin
      d = rg ? rv : 16'($urandom);
      m = rg ? 2'h3 : 2'($urandom);
      if (rd)
        rdQ.push_back(rg ? cfgShadow[a[0]] : shadow[p]);
      else
        wrQ.push_back({m, d});
      if (!rd && rg)
        cfgShadow[a[0]] = d;
      if (!rd && !rg && !m[1])
        shadow[p][15:8] = d[15:8];
      if (!rd && !rg && !m[0])
        shadow[p][7:0] = d[7:0];
      p = lin ? p + 6'h01 : {p[5:3], p[2:0] + 3'h1};
    end
    @(negedge sys_clk);
    check({47'h0, 1'b1}, {47'h0, reqReady});
    dblLat = 1'($urandom);
    {reqRead, reqReg, reqLinear, reqAddr, reqLen} = {rd, rg, lin, ra, 8'(n)};
    reqValid = 1'b1;
    @(negedge sys_clk);
    reqValid = 1'b0;
    t = 0;
    while (busy !== 1'b0 && t < 5000) begin
      check({46'h0, ~linkClk, 1'b0}, {46'h0, clkComp, reqReady});
      @(negedge sys_clk);
      t++;
    end
    if (t >= 5000)
      fail_count++;
    check({rd, rg, (rg && !rd) | lin, ra[31:3], 13'h0, ra[2:0]}, lastCa);
    check(48'h0, {32'h0, 16'(rdQ.size()), 16'(wrQ.size())});
    check(48'h0, {47'h0, ruleBreak});
    $display("transfer done: rd=%0d reg=%0d lin=%0d addr=%0d len=%0d", rd, rg, lin, a, n);
  endtask

  always @(posedge sys_clk)
    wrTaken <= wrValid && wrReady;

  // write words offered with random stalls
  always @(negedge sys_clk) begin
    if (wrTaken)
      wrQ.delete(0);
    {wrMask, wrData} = (wrQ.size() > 0) ? wrQ[0] : 18'($urandom);
    wrValid = (wrQ.size() > 0) && ($urandom % 4 != 0);
  end

  // an unexpected word always mismatches
  always @(posedge sys_clk) begin
    if (rdValid === 1'b1)
      check({32'h0, (rdQ.size() > 0) ? rdQ.pop_front() : ~rdData}, {32'h0, rdData});
  end

  initial begin
    #1_000_000;
    fail_count++;
    give_verdict();
  end

  initial begin
    void'($urandom(96));
    for (int i = 0; i < 64; i++) shadow[i] = {8'h40 + 8'(i), 8'hBF - 8'(i)};
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    xfer(1'b0, 1'b0, 1'b1, 6'd60, 6, 16'h0);
    xfer(1'b1, 1'b0, 1'b1, 6'd60, 6, 16'h0);
    xfer(1'b1, 1'b0, 1'b0, 6'd13, 10, 16'h0);
    xfer(1'b0, 1'b0, 1'b0, 6'd21, 5, 16'h0);
    xfer(1'b1, 1'b0, 1'b1, 6'd16, 8, 16'h0);
    xfer(1'b1, 1'b1, 1'b0, 6'd0, 1, 16'h0);
    xfer(1'b0, 1'b1, 1'b0, 6'd0, 1, 16'h8F3F);
    latCount = 4'h3;
    xfer(1'b1, 1'b1, 1'b1, 6'd0, 1, 16'h0);
    for (int i = 0; i < 12; i++) xfer(1'($urandom), 1'b0, 1'($urandom), 6'($urandom), 1 + $urandom % 8, 16'h0);
    give_verdict();
  end
endmodule
